// ===== common/link_lane_scrambler_defs.svh
// constants for the per-sublink lane scrambler
`ifndef LINK_LANE_SCRAMBLER_DEFS_SVH
`define LINK_LANE_SCRAMBLER_DEFS_SVH
`define LLS_PATTERN_SHIFT_REGISTER_LEN     23
`define LLS_FB_LONG      23
`define LLS_FB_SHORT     18
`define LLS_SEED         23'h7FFFFF
`define LLS_BT_MAX       8
`define LLS_LANES        9
`define LLS_FIFO_DEPTH   16
// tap delays per lane for bit-time 0, lanes 0..7 then framing lane
`define LLS_TAP_A        '{13, 10, 12,  8,  9,  9, 11, 11, 13}
`define LLS_TAP_B        '{18, 17, 16, 16, 15, 18, 13, 14, 14}
`endif

// ===== common/link_lane_scrambler_pkg.sv
// types shared by the lane scrambler design
package link_lane_scrambler_pkg;
    typedef logic [22:0] pattern_shift_register_t;
    // one clock of a sublink: bit-time k of each lane sits at bit k
    typedef struct packed {
        logic [7:0]      framing_lane;
        logic [7:0][7:0] cmd_addr_data_lane;
    } lane_word_t;
    typedef enum logic [0:0] {SEED_HOLD, RUN} scr_state_t;
    // complete state of the link-clock side
    typedef struct packed {
        scr_state_t st;
        pattern_shift_register_t      pattern_shift_register;
        lane_word_t out;
        logic       out_valid;
        logic [1:0] stop_sync;
        logic [2:0] train_sync;
        logic [2:0] retry_sync;
    } link_side_t;
endpackage : link_lane_scrambler_pkg

// ===== rtl/link_lane_scrambler.sv
// per-sublink lane scrambler with a clock-crossing input fifo
`timescale 1ns/1ps
`default_nettype none
`include "link_lane_scrambler_defs.svh"

// ----------------------------------------------------------------------
// dual-clock fifo, gray pointers
// ----------------------------------------------------------------------
module lls_async_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = `LLS_FIFO_DEPTH
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_rst_n,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst_n,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);

    // gray pointers only wrap cleanly on a power-of-two depth
    // refused at elaboration, not left to misbehave at run time
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_r;
    logic [AW:0]      wgray_r;
    logic [AW:0]      rbin_r;
    logic [AW:0]      rgray_r;
    logic [AW:0]      rg_s1_r;
    logic [AW:0]      rg_s2_r;
    logic [AW:0]      wg_s1_r;
    logic [AW:0]      wg_s2_r;
    logic [AW:0]      wbin_nxt;
    logic [AW:0]      rbin_nxt;

    // full compares against the read pointer seen through two flops
    assign wr_ready = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
    assign rd_valid = (rgray_r != wg_s2_r);
    assign rd_data  = mem[rbin_r[AW-1:0]];
    assign wbin_nxt = wbin_r + {{AW{1'b0}}, (wr_valid & wr_ready)};
    assign rbin_nxt = rbin_r + {{AW{1'b0}}, (rd_valid & rd_ready)};

    // write side
    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    // storage has no reset, it is only read behind a valid pointer
    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    // read side
    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
        end
    end
endmodule : lls_async_fifo

// ----------------------------------------------------------------------
// scrambler top
// ----------------------------------------------------------------------
// Functional notes
// - pattern comes from 23-bit shift register, feedback x^-23 + x^-18 + 1
// - each lane pattern is XOR of two distinct taps of one register
// - bit-time 0 taps per lane as tabled; clock lane unscrambled
// - bit-time k of a clock uses lane taps reduced by k
// - register advances exactly by bit-times per clock; delays 1..7 unused (code advances only on clocks that take a word from the fifo)
// - register seeded all ones after reset, link stop or retry disconnect
// - seeded register stays frozen until third training state ends
// - first operational bit-time, a NOP start, scrambled with seed state
// - periodic crc bit-times scrambled like any other, no bypass
// - one independent scrambler instance per sublink, ganged or not
// - one instance covers eight data lanes and framing lane; clock lane not carried
module link_lane_scrambler #(
    parameter int BITS_PER_CLK = `LLS_BT_MAX,
    parameter int FIFO_DEPTH   = `LLS_FIFO_DEPTH
) (
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire link_lane_scrambler_pkg::lane_word_t in_data,
    input  wire logic                        training_done,
    input  wire logic                        retry_disconnect,
    input  wire logic                        link_clk,
    input  wire logic                        link_stop_request_n,
    output logic                             tx_valid,
    output link_lane_scrambler_pkg::lane_word_t tx_lanes,
    output logic                             scrambler_running
);
    localparam int TAP_A [`LLS_LANES] = `LLS_TAP_A;
    localparam int TAP_B [`LLS_LANES] = `LLS_TAP_B;

    // taps 1..7 avoided
    // more than eight bit-times per clock would reach the shortest taps
    if (BITS_PER_CLK < 1 || BITS_PER_CLK > `LLS_BT_MAX) begin : g_bad_bpc
        $error("bits per clock must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // pattern functions
    // ------------------------------------------------------------------
    // data xor pattern
    function automatic link_lane_scrambler_pkg::lane_word_t scramble(
        input link_lane_scrambler_pkg::lane_word_t d,
        input link_lane_scrambler_pkg::pattern_shift_register_t      h
    );
        logic [`LLS_LANES-1:0][7:0] w;
        w = d;
        for (int l = 0; l < `LLS_LANES; l++) begin
            for (int k = 0; k < BITS_PER_CLK; k++) begin
                // stage index is delay minus one
                w[l][k] = w[l][k] ^ h[TAP_A[l] - k - 1] ^ h[TAP_B[l] - k - 1];
            end
        end
        return link_lane_scrambler_pkg::lane_word_t'(w);
    endfunction : scramble

    // feedback from delays 23 and 18
    function automatic link_lane_scrambler_pkg::pattern_shift_register_t advance(
        input link_lane_scrambler_pkg::pattern_shift_register_t h
    );
        logic [`LLS_BT_MAX-1:0]         n;
        link_lane_scrambler_pkg::pattern_shift_register_t r;
        n = '0;
        r = h;
        // new bits never reach back past the current clock's state
        for (int j = 0; j < BITS_PER_CLK; j++) begin
            n[j] = h[`LLS_FB_LONG - 1 - j] ^ h[`LLS_FB_SHORT - 1 - j];
        end
        for (int i = 0; i < `LLS_PATTERN_SHIFT_REGISTER_LEN; i++) begin
            if (i < BITS_PER_CLK) begin
                r[i] = n[BITS_PER_CLK - 1 - i];
            end else begin
                r[i] = h[i - BITS_PER_CLK];
            end
        end
        return r;
    endfunction : advance

    // ------------------------------------------------------------------
    // core-clock side
    // ------------------------------------------------------------------
    logic [1:0] core_rst_r;
    logic [1:0] link_rst_r;
    logic       core_rst_n;
    logic       link_rst_n;
    logic       retry_tgl_r;
    logic       retry_tgl_nxt;

    // reset released through two flops in each domain
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_rst_r <= 2'h0;
        end else begin
            core_rst_r <= {core_rst_r[0], 1'b1};
        end
    end
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_rst_r <= 2'h0;
        end else begin
            link_rst_r <= {link_rst_r[0], 1'b1};
        end
    end
    assign core_rst_n = core_rst_r[1];
    assign link_rst_n = link_rst_r[1];

    // retry pulse becomes a toggle so it survives the crossing
    always_comb begin
        retry_tgl_nxt = retry_tgl_r ^ retry_disconnect;
    end
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            retry_tgl_r <= 1'b0;
        end else begin
            retry_tgl_r <= retry_tgl_nxt;
        end
    end

    // training level held in a flop before it crosses
    logic train_core_r;
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            train_core_r <= 1'b0;
        end else begin
            train_core_r <= training_done;
        end
    end

    // ------------------------------------------------------------------
    // fifo between the domains
    // ------------------------------------------------------------------
    logic                                fifo_valid;
    logic                                fifo_ready;
    link_lane_scrambler_pkg::lane_word_t fifo_data;

    lls_async_fifo #(
        .WIDTH ($bits(link_lane_scrambler_pkg::lane_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .wr_clk   (ref_clk),
        .wr_rst_n (core_rst_n),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  (in_data),
        .rd_clk   (link_clk),
        .rd_rst_n (link_rst_n),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_ready),
        .rd_data  (fifo_data)
    );

    // ------------------------------------------------------------------
    // link-clock side
    // ------------------------------------------------------------------
    // this instance serves one sublink only
    // eight data lanes plus framing; clock lane not carried
    link_lane_scrambler_pkg::link_side_t q_r;
    link_lane_scrambler_pkg::link_side_t q_nxt;
    logic                                disconnect;
    logic                                train_rise;

    // logic reads only the second stage of the two-flop stop synchroniser and the second and third of the others, never the first
    assign disconnect = ~q_r.stop_sync[1] | (q_r.retry_sync[1] ^ q_r.retry_sync[2]);
    assign train_rise = q_r.train_sync[1] & ~q_r.train_sync[2];
    // stalling here back-pressures the fifo and then the core
    assign fifo_ready = (q_r.st == link_lane_scrambler_pkg::RUN) && !disconnect;

    always_comb begin
        q_nxt            = q_r;
        q_nxt.stop_sync  = {q_r.stop_sync[0], link_stop_request_n};
        q_nxt.train_sync = {q_r.train_sync[1:0], train_core_r};
        q_nxt.retry_sync = {q_r.retry_sync[1:0], retry_tgl_r};
        q_nxt.out_valid  = 1'b0;
        case (q_r.st)
            link_lane_scrambler_pkg::SEED_HOLD: begin
                if (train_rise && !disconnect) begin
                    q_nxt.st = link_lane_scrambler_pkg::RUN;
                end
            end
            link_lane_scrambler_pkg::RUN: begin
                // first word uses the seed state
                // every word scrambled, crc slots included
                if (fifo_valid && fifo_ready) begin
                    q_nxt.out       = scramble(fifo_data, q_r.pattern_shift_register);
                    q_nxt.out_valid = 1'b1;
                    q_nxt.pattern_shift_register = advance(q_r.pattern_shift_register);
                end
            end
            default: begin
                q_nxt.st = link_lane_scrambler_pkg::SEED_HOLD;
            end
        endcase
        if (disconnect) begin
            q_nxt.st                     = link_lane_scrambler_pkg::SEED_HOLD;
            q_nxt.pattern_shift_register = `LLS_SEED;
            q_nxt.out_valid              = 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            q_r                        <= '0;
            q_r.st                     <= link_lane_scrambler_pkg::SEED_HOLD;
            q_r.pattern_shift_register <= `LLS_SEED;
            q_r.stop_sync              <= 2'h3;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tx_valid          = q_r.out_valid;
    assign tx_lanes          = q_r.out;
    assign scrambler_running = (q_r.st == link_lane_scrambler_pkg::RUN);
endmodule : link_lane_scrambler
`default_nettype wire

// ===== tb/link_lane_scrambler_monitor.sv
// port checker for the lane scrambler, bound to its top
`timescale 1ns/1ps
`default_nettype none
module link_lane_scrambler_monitor #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic                                ref_clk,
    input wire logic                                reset_n,
    input wire logic                                in_valid,
    input wire logic                                in_ready,
    input wire logic                                training_done,
    input wire logic                                retry_disconnect,
    input wire logic                                link_clk,
    input wire logic                                link_stop_request_n,
    input wire logic                                tx_valid,
    input wire link_lane_scrambler_pkg::lane_word_t tx_lanes,
    input wire logic                                scrambler_running
);
    // ------------------------------------------------------------
    // words taken while the pattern is held
    // ------------------------------------------------------------
    logic [4:0] held_cnt_r;
    logic [4:0] held_cnt_nxt;
    // cleared once running, since pops make the count meaningless
    always_comb begin
        held_cnt_nxt = held_cnt_r;
        if (scrambler_running) held_cnt_nxt = 5'h00;
        else if (in_valid && in_ready && held_cnt_r != 5'h1F) held_cnt_nxt = held_cnt_r + 5'h01;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) held_cnt_r <= 5'h00;
        else held_cnt_r <= held_cnt_nxt;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_FULL_REFUSES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        int'(held_cnt_r) >= FIFO_DEPTH |-> !in_ready) else $error("full fifo still ready");
    AST_RETRY_DROPS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        retry_disconnect |-> ##[1:40] !scrambler_running) else $error("retry kept running");
    AST_TRAIN_RUNS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(training_done) && link_stop_request_n |-> ##[1:60] scrambler_running)
        else $error("training end did not start run");
    AST_STOP_DROPS: assert property (@(posedge link_clk) disable iff (!reset_n)
        !link_stop_request_n [*3] |=> !scrambler_running) else $error("link stop kept running");
    AST_STOP_SILENT: assert property (@(posedge link_clk) disable iff (!reset_n)
        !link_stop_request_n [*4] |=> !tx_valid) else $error("word sent during link stop");
    AST_HELD_SILENT: assert property (@(posedge link_clk) disable iff (!reset_n)
        !scrambler_running |=> !tx_valid) else $error("word sent while held");
    AST_LANES_STAND: assert property (@(posedge link_clk) disable iff (!reset_n)
        !tx_valid |-> $stable(tx_lanes)) else $error("lanes moved without valid");
    AST_RUN_AFTER_STOP: assert property (@(posedge link_clk) disable iff (!reset_n)
        $rose(scrambler_running) |-> $past(link_stop_request_n, 3))
        else $error("run began too soon after stop");
    // main scenarios reached
    COV_FULL: cover property (@(posedge ref_clk) in_valid && !in_ready);
    COV_RETRY: cover property (@(posedge ref_clk) retry_disconnect);
    COV_STOP: cover property (@(posedge link_clk) !link_stop_request_n && scrambler_running);
    COV_SEND: cover property (@(posedge link_clk) $rose(scrambler_running) ##[1:20] tx_valid);
endmodule : link_lane_scrambler_monitor
bind link_lane_scrambler link_lane_scrambler_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .ref_clk(ref_clk), .reset_n(reset_n), .in_valid(in_valid), .in_ready(in_ready),
    .training_done(training_done), .retry_disconnect(retry_disconnect), .link_clk(link_clk),
    .link_stop_request_n(link_stop_request_n), .tx_valid(tx_valid), .tx_lanes(tx_lanes),
    .scrambler_running(scrambler_running));
`default_nettype wire

// ===== tb/link_lane_scrambler_tb_top.sv
// testbench top: core writer, peer model and scenarios
`timescale 1ns/1ps
`default_nettype none
module link_lane_scrambler_tb_top;
    logic ref_clk, link_clk, reset_n, in_valid, in_ready, training_done, retry_disconnect;
    logic link_stop_request_n, tx_valid, scrambler_running, hold, rx_valid;
    link_lane_scrambler_pkg::lane_word_t in_data, tx_lanes, rx_data;
    link_lane_scrambler_pkg::lane_word_t exp_q [$];
    int errors, compares, tx_seen;
    // ------------------------------------------------------------
    // clocks, link clock unrelated in phase
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    link_lane_scrambler u_link_lane_scrambler (.ref_clk(ref_clk), .reset_n(reset_n),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .training_done(training_done), .retry_disconnect(retry_disconnect), .link_clk(link_clk),
        .link_stop_request_n(link_stop_request_n), .tx_valid(tx_valid), .tx_lanes(tx_lanes),
        .scrambler_running(scrambler_running));
    lls_peer_descrambler u_lls_peer_descrambler (.link_clk(link_clk), .reset_n(reset_n),
        .hold(hold), .link_stop_request_n(link_stop_request_n), .tx_valid(tx_valid),
        .tx_lanes(tx_lanes), .rx_valid(rx_valid), .rx_data(rx_data));
    // ------------------------------------------------------------
    // compares and helpers
    // ------------------------------------------------------------
    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_word(input link_lane_scrambler_pkg::lane_word_t got, exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    // word 0 stands for the leading nop
    function automatic link_lane_scrambler_pkg::lane_word_t mk(input int i);
        return (i == 0) ? 72'h0 : {8'(i * 37), {8{8'(i * 11 + 5)}}} ^ 72'h00F0E1D2C3B4A59687;
    endfunction : mk
    // peer output checked in arrival order, first two words by hand-worked pattern
    always @(posedge link_clk) begin
        #1;
        if (tx_valid === 1'b1) tx_seen++;
        // seed of all ones gives a zero pattern on every lane
        if (tx_valid === 1'b1 && tx_seen == 1) cmp_word(tx_lanes, mk(0));
        // after one advance: stages 0..7 zero, 8..22 still one
        if (tx_valid === 1'b1 && tx_seen == 2) begin
            cmp_word(tx_lanes ^ mk(1), 72'h203818FE7EFFF0FCE0);
        end
        if (rx_valid === 1'b1 && exp_q.size() == 0) cmp_bit(1'b1, 1'b0);
        else if (rx_valid === 1'b1) cmp_word(rx_data, exp_q.pop_front());
    end
    // valid is left high so back-to-back words see no low gap between them
    task automatic send(input link_lane_scrambler_pkg::lane_word_t w);
        in_valid = 1'b1;
        in_data  = w;
        while (in_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        exp_q.push_back(w);
    endtask : send
    task automatic train();
        hold          = 1'b0;
        training_done = 1'b1;
        for (int i = 0; i < 100 && scrambler_running !== 1'b1; i++) @(posedge ref_clk) #1;
        cmp_bit(scrambler_running, 1'b1);
    endtask : train
    task automatic drain();
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge ref_clk) #1;
        cmp_bit(exp_q.size() == 0, 1'b1);
    endtask : drain
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fill();
        int seen;
        seen = tx_seen;
        for (int i = 0; i < 16; i++) send(mk(i));
        in_data = mk(99);
        repeat (5) @(posedge ref_clk) #1;
        cmp_bit(in_ready, 1'b0);
        cmp_bit(tx_seen == seen, 1'b1);
        in_valid = 1'b0;
        train();
        drain();
    endtask : t_fill
    task automatic t_disconnect(input bit stop);
        for (int i = 0; i < 20; i++) send(mk(i + 20));
        in_valid = 1'b0;
        drain();
        // a short second burst finds the pattern stalled on the empty fifo
        for (int i = 0; i < 3; i++) send(mk(i + 40));
        in_valid = 1'b0;
        drain();
        hold          = 1'b1;
        training_done = 1'b0;
        if (stop) link_stop_request_n = 1'b0;
        else retry_disconnect = 1'b1;
        @(posedge ref_clk) #1;
        retry_disconnect = 1'b0;
        repeat (60) @(posedge ref_clk) #1;
        cmp_bit(scrambler_running, 1'b0);
        link_stop_request_n = 1'b1;
        repeat (20) @(posedge ref_clk) #1;
        for (int i = 0; i < 4; i++) send(mk(i + 50));
        in_valid = 1'b0;
        train();
        drain();
    endtask : t_disconnect
    task automatic wrap_up();
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // about 700 core cycles expected, 20000 allowed
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        {reset_n, in_valid, training_done, retry_disconnect} = 4'h0;
        {link_stop_request_n, hold} = 2'h3;
        in_data = 72'h0;
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge ref_clk) #1;
        t_fill();
        t_disconnect(1'b0);
        t_disconnect(1'b1);
        wrap_up();
    end
endmodule : link_lane_scrambler_tb_top
`default_nettype wire

// ===== tb/lls_peer_descrambler.sv
// peer link device model: regenerates the pattern and descrambles
`timescale 1ns/1ps
`default_nettype none
`include "link_lane_scrambler_defs.svh"
module lls_peer_descrambler #(
    parameter int BITS_PER_CLK = `LLS_BT_MAX
) (
    input  wire logic                                link_clk,
    input  wire logic                                reset_n,
    input  wire logic                                hold,
    input  wire logic                                link_stop_request_n,
    input  wire logic                                tx_valid,
    input  wire link_lane_scrambler_pkg::lane_word_t tx_lanes,
    output logic                                     rx_valid,
    output link_lane_scrambler_pkg::lane_word_t      rx_data
);
    typedef struct packed {
        link_lane_scrambler_pkg::pattern_shift_register_t      h;
        logic                                v;
        link_lane_scrambler_pkg::lane_word_t d;
    } peer_t;
    peer_t s_r;
    peer_t s_nxt;
    localparam int TA [9] = `LLS_TAP_A;
    localparam int TB [9] = `LLS_TAP_B;
    always_comb begin
        s_nxt   = s_r;
        s_nxt.v = 1'b0;
        if (hold || !link_stop_request_n) begin
            s_nxt.h = `LLS_SEED;
        end else if (tx_valid) begin
            s_nxt.v = 1'b1;
            s_nxt.d = tx_lanes;
            for (int l = 0; l < `LLS_LANES; l++) begin
                for (int k = 0; k < BITS_PER_CLK; k++) begin
                    if (l < 8) s_nxt.d.cmd_addr_data_lane[l][k] ^= s_r.h[TA[l]-k-1] ^ s_r.h[TB[l]-k-1];
                    else s_nxt.d.framing_lane[k] ^= s_r.h[TA[l]-k-1] ^ s_r.h[TB[l]-k-1];
                end
            end
            for (int j = 0; j < BITS_PER_CLK; j++) begin
                s_nxt.h = {s_nxt.h[21:0], s_nxt.h[22] ^ s_nxt.h[17]};
            end
        end
    end
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) s_r <= {`LLS_SEED, 1'b0, 72'h0};
        else s_r <= s_nxt;
    end
    assign rx_valid = s_r.v;
    assign rx_data  = s_r.d;
endmodule : lls_peer_descrambler
`default_nettype wire
